//--- rtl/cpu_memory_map_map.vh
// constants for the data-space decoder, program window and arithmetic unit
`ifndef CPU_MEMORY_MAP_MAP_VH
`define CPU_MEMORY_MAP_MAP_VH
`define DATA_W            16
`define PROG_W            24
`define SFR_LAST          16'h07ff
`define RAM_FIRST         16'h0800
`define RAM_LAST          16'h27ff
`define RAM_WORDS         4096
`define WIN_FIRST         16'h8000
`define PROG_LAST         24'h00abfe
`define PROG_WORDS        22016
`define CFG_PAGE_FIRST    24'h00a800
`define WREG_COUNT        16
`define ACC_REG           4'h0
`define FP_REG            4'he
`define SP_REG            4'hf
`define PC_ADDR           16'h0020
`define DIV_CYCLES        19
`define WIN_WAIT          2
`endif

//--- rtl/arith_unit.v
// hardware multiplier and iterative divider
`timescale 1ns/1ps
`default_nettype none
`include "cpu_memory_map_map.vh"
module arith_unit (
    input  wire        clk,        // system clock
    input  wire        sys_rst,    // synchronous reset
    input  wire [15:0] op_a,       // multiplicand
    input  wire [15:0] op_b,       // multiplier or divisor
    input  wire [31:0] dividend,   // 32-bit dividend
    input  wire        div_start,  // start divide pulse
    output wire [31:0] product,    // 32-bit product
    output reg  [15:0] quot_q,     // quotient
    output reg  [15:0] rem_q,      // remainder
    output wire        div_busy    // divide running
);
    // ************************************************
    // multiplier and divider
    // ************************************************
    reg [4:0]  cnt_q;
    reg [31:0] num_q;
    reg [16:0] part_q;
    reg [15:0] dsr_q;
    // one spare bit so a shifted remainder at or above 2^16 keeps a true sign
    wire [17:0] trial = {1'b0, part_q[15:0], num_q[31]} - {2'b00, dsr_q};
    assign product  = op_a * op_b;
    assign div_busy = (cnt_q != 5'h00);
    // restoring divide, one bit a cycle plus overhead, 19 cycles total
    always @(posedge clk) begin
        if (sys_rst) begin
            cnt_q  <= 5'h00;
            num_q  <= 32'h0000_0000;
            part_q <= 17'h0_0000;
            dsr_q  <= 16'h0000;
            quot_q <= 16'h0000;
            rem_q  <= 16'h0000;
        end else if (div_start && !div_busy) begin
            cnt_q  <= 5'd`DIV_CYCLES;
            // high half seeds the remainder; quotient must fit 16 bits
            num_q  <= {dividend[15:0], 16'h0000};
            part_q <= {1'b0, dividend[31:16]};
            dsr_q  <= op_b;
        end else if (div_busy) begin
            cnt_q <= cnt_q - 5'h01;
            if (cnt_q > 5'd3) begin
                num_q <= {num_q[30:0], ~trial[17]};
                if (!trial[17])
                    part_q <= trial[16:0];
                else
                    part_q <= {part_q[15:0], num_q[31]};
            end
            if (cnt_q == 5'h01) begin
                quot_q <= num_q[15:0];
                rem_q  <= part_q[15:0];
            end
        end
    end
endmodule // arith_unit
`default_nettype wire

//--- rtl/cpu_memory_map.v
// data-space decoder, working registers, ram, program window and traps
`timescale 1ns/1ps
`default_nettype none
`include "cpu_memory_map_map.vh"
module cpu_memory_map (
    input  wire        clk,          // 40 MHz clock
    input  wire        sys_rst,      // synchronous reset
    input  wire        d_req,        // data access request
    input  wire        d_we,         // write when high
    input  wire        d_byte,       // byte access when high
    input  wire [15:0] d_addr,       // byte address
    input  wire [15:0] d_wdata,      // write data, byte in low lane
    output reg  [15:0] d_rdata_q,    // read data
    output wire        d_ready,      // access completes this cycle
    output reg         trap_rst_q,   // address trap core reset pulse
    input  wire [7:0]  win_page,     // window segment select
    output wire [23:0] p_addr,       // program memory address
    input  wire [23:0] p_rdata,      // program memory word
    input  wire [15:0] pc_in,        // program counter from core
    output reg         pc_we_q,      // write to program counter pulse
    input  wire [3:0]  ra_sel,       // operand a register
    input  wire [3:0]  rb_sel,       // operand b register
    input  wire [3:0]  rd_sel,       // destination register
    input  wire        mul_go,       // store product into pair
    input  wire        div_go,       // start divide of pair by rb
    input  wire        push,         // push operand a on stack
    input  wire        lnk_go,       // link frame
    input  wire        ulnk_go,      // unlink frame
    output wire        div_busy,     // divider running
    output wire [15:0] ra_data,      // operand a value
    output wire [15:0] acc_data      // accumulator value
);
    // ************************************************
    // storage
    // ************************************************
    reg  [15:0] wreg_q [0:`WREG_COUNT-1];
    reg  [15:0] ram_q  [0:`RAM_WORDS-1];
    reg  [1:0]  wait_q;
    reg         div_run_q;
    reg  [3:0]  div_dst_q;
    integer     i;
    wire [31:0] product;
    wire [15:0] quot;
    wire [15:0] rem;
    wire [3:0]  rd_even = {rd_sel[3:1], 1'b0};
    wire [3:0]  ra_even = {ra_sel[3:1], 1'b0};
    wire [15:0] sp      = wreg_q[`SP_REG];
    wire [15:0] fp      = wreg_q[`FP_REG];

    // ************************************************
    // address decode
    // ************************************************
    wire in_wreg = (d_addr < 16'h0020);
    wire in_pc   = ({d_addr[15:1], 1'b0} == `PC_ADDR);
    wire in_ram  = (d_addr >= `RAM_FIRST) && (d_addr <= `RAM_LAST);
    wire in_win  = d_addr[15];
    wire odd_bad = d_addr[0] && !d_byte;
    wire [3:0]  w_idx = d_addr[4:1];
    wire [11:0] r_idx = d_addr[12:1] - 12'h400;
    // window: page selects 16K-word segment, program address kept even
    // page zero reaches the vectors and words up to 0x7ffe; no page reaches 0x8000 to 0xabfe
    assign p_addr = {win_page[7:0], 1'b0, 15'h0000} + {9'h000, d_addr[14:1], 1'b0};
    wire win_slow = d_req && !d_we && in_win && !odd_bad;
    assign d_ready  = !win_slow || (wait_q == 2'd`WIN_WAIT);
    assign ra_data  = wreg_q[ra_sel];
    assign acc_data = wreg_q[`ACC_REG];
    wire [15:0] p_low = p_rdata[15:0];

    arith_unit u_arith (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .op_a      (wreg_q[ra_sel]),
        .op_b      (wreg_q[rb_sel]),
        .dividend  ({wreg_q[ra_even + 4'h1], wreg_q[ra_even]}),
        .div_start (div_go),
        .product   (product),
        .quot_q    (quot),
        .rem_q     (rem),
        .div_busy  (div_busy)
    );

    // ************************************************
    // read path, little-endian byte lanes
    // ************************************************
    reg [15:0] word_rd;
    always @* begin
        word_rd = 16'h0000;
        if (in_wreg)
            word_rd = wreg_q[w_idx];
        else if (in_pc)
            word_rd = pc_in;
        else if (in_ram)
            word_rd = ram_q[r_idx];
        else if (in_win)
            word_rd = p_low;
    end

    // ************************************************
    // window wait counter
    // ************************************************
    always @(posedge clk) begin
        if (sys_rst)
            wait_q <= 2'd0;
        else if (win_slow && !d_ready)
            wait_q <= wait_q + 2'd1;
        else
            wait_q <= 2'd0;
    end

    // ************************************************
    // data access, traps and register updates
    // ************************************************
    always @(posedge clk) begin
        pc_we_q    <= 1'b0;
        trap_rst_q <= 1'b0;
        if (sys_rst) begin
            for (i = 0; i < `WREG_COUNT; i = i + 1)
                wreg_q[i] <= 16'h0000;
            wreg_q[`SP_REG] <= `RAM_FIRST + 16'h0050;    // above reserved area
            d_rdata_q <= 16'h0000;
            div_run_q <= 1'b0;
            div_dst_q <= 4'h0;
        end else begin
            if (d_req && odd_bad) begin
                trap_rst_q <= 1'b1;
            end else if (d_req && d_ready && !d_we) begin
                if (d_byte)
                    d_rdata_q <= {8'h00, d_addr[0] ? word_rd[15:8] : word_rd[7:0]};
                else
                    d_rdata_q <= word_rd;
            end else if (d_req && d_we && !in_win) begin
                if (in_wreg) begin
                    if (!d_byte)
                        wreg_q[w_idx] <= d_wdata;
                    else if (d_addr[0])
                        wreg_q[w_idx][15:8] <= d_wdata[7:0];
                    else
                        wreg_q[w_idx][7:0] <= d_wdata[7:0];
                end else if (in_pc) begin
                    pc_we_q <= 1'b1;
                end else if (in_ram) begin
                    if (!d_byte)
                        ram_q[r_idx] <= d_wdata;
                    else if (d_addr[0])
                        ram_q[r_idx][15:8] <= d_wdata[7:0];
                    else
                        ram_q[r_idx][7:0] <= d_wdata[7:0];
                end
            end
            // multiply result to aligned pair, high half in odd register
            if (mul_go) begin
                wreg_q[rd_even]        <= product[15:0];
                wreg_q[rd_even + 4'h1] <= product[31:16];
            end
            if (div_go && !div_busy) begin
                div_run_q <= 1'b1;
                div_dst_q <= rd_even;
            end
            if (div_run_q && !div_busy) begin
                div_run_q <= 1'b0;
                wreg_q[div_dst_q]        <= quot;
                wreg_q[div_dst_q + 4'h1] <= rem;
            end
            // stack grows upward, frame pointer links frames
            if (push) begin
                ram_q[sp[12:1] - 12'h400] <= wreg_q[ra_sel];
                wreg_q[`SP_REG] <= sp + 16'h0002;
            end else if (lnk_go) begin
                ram_q[sp[12:1] - 12'h400] <= fp;
                wreg_q[`FP_REG] <= sp + 16'h0002;
                wreg_q[`SP_REG] <= sp + 16'h0002;
            end else if (ulnk_go) begin
                wreg_q[`SP_REG] <= fp - 16'h0002;
                wreg_q[`FP_REG] <= ram_q[fp[12:1] - 12'h401];
            end
        end
    end
endmodule // cpu_memory_map
`default_nettype wire

//--- bench/cpu_memory_map_props.sv
// port assertions for the data-space decoder
`timescale 1ns/1ps
`default_nettype none
module cpu_memory_map_props (
    input wire logic        clk,        // clock
    input wire logic        sys_rst,    // reset
    input wire logic        d_req,      // request
    input wire logic        d_we,       // write
    input wire logic        d_byte,     // byte access
    input wire logic [15:0] d_addr,     // address
    input wire logic [15:0] d_rdata_q,  // read data
    input wire logic        d_ready,    // ready
    input wire logic        trap_rst_q, // trap pulse
    input wire logic [7:0]  win_page,   // segment
    input wire logic [23:0] p_addr,     // program address
    input wire logic [23:0] p_rdata,    // program word
    input wire logic [15:0] pc_in,      // pc value
    input wire logic        pc_we_q,    // pc write
    input wire logic        div_go,     // divide start
    input wire logic        div_busy    // divide busy
);
    // ****************************************
    // helpers and properties
    // ****************************************
    wire logic        tk  = d_req & d_ready;
    wire logic        odd = tk & ~d_byte & d_addr[0];
    wire logic [15:0] plo = p_rdata[15:0];
    // window read that is not refused as an odd word access
    wire logic        win_rd = d_req & d_addr[15] & ~d_we & ~(d_addr[0] & ~d_byte);
    logic      [5:0]  busy_q;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // counts consecutive busy cycles of the divider
    always_ff @(posedge clk) busy_q <= (sys_rst | ~div_busy) ? 6'h00 : busy_q + 6'h01;
    odd_trap_a: assert property (odd |=> trap_rst_q)
        else $error("odd word access gave no trap");
    trap_cause_a: assert property (trap_rst_q |-> $past(odd))
        else $error("trap without odd word access");
    win_map_a: assert property (d_req & d_addr[15] |->
        p_addr == {win_page, 1'b0, d_addr[14:1], 1'b0})
        else $error("window program address wrong");
    win_wait_a: assert property ($rose(d_req) & win_rd |->
        ~d_ready ##1 ~d_ready ##1 d_ready)
        else $error("window read wait wrong");
    win_data_a: assert property (tk & win_rd & ~d_byte |=> d_rdata_q == $past(plo))
        else $error("window read data wrong");
    pc_read_a: assert property (tk & ~d_we & ~d_byte & d_addr == 16'h0020 |=> d_rdata_q == $past(pc_in))
        else $error("pc read wrong");
    pc_write_a: assert property (tk & d_we & ~d_byte & d_addr == 16'h0020 |=> pc_we_q)
        else $error("pc write gave no pulse");
    div_start_a: assert property (div_go & ~div_busy |=> div_busy)
        else $error("divide did not start");
    div_len_a: assert property ($fell(div_busy) |-> busy_q == 6'h13)
        else $error("divide length wrong");
    cover property (tk & d_addr[15] & ~d_we);
    cover property (odd);
    cover property (div_go & ~div_busy);
endmodule // cpu_memory_map_props
bind cpu_memory_map cpu_memory_map_props chk (.clk(clk), .sys_rst(sys_rst), .d_req(d_req),
    .d_we(d_we), .d_byte(d_byte), .d_addr(d_addr), .d_rdata_q(d_rdata_q), .d_ready(d_ready),
    .trap_rst_q(trap_rst_q), .win_page(win_page), .p_addr(p_addr), .p_rdata(p_rdata),
    .pc_in(pc_in), .pc_we_q(pc_we_q), .div_go(div_go), .div_busy(div_busy));
`default_nettype wire

//--- bench/cpu_memory_map_test.sv
// self-checking bench for the data-space decoder
`timescale 1ns/1ps
`default_nettype none
module cpu_memory_map_test;
    logic        clk = 1'b0, sys_rst = 1'b1, d_req = 1'b0, d_we = 1'b0, d_byte = 1'b0;
    logic        mul_go = 1'b0, div_go = 1'b0, push = 1'b0, lnk_go = 1'b0, ulnk_go = 1'b0;
    logic [15:0] d_addr = 16'h0000, d_wdata = 16'h0000, pc_in = 16'hbeef, r;
    logic [7:0]  win_page = 8'h03;
    logic [23:0] p_rdata = 24'hc1d2e3, p_addr, pa;
    logic [3:0]  ra_sel = 4'h0, rb_sel = 4'h0, rd_sel = 4'h0;
    wire  [15:0] d_rdata_q, ra_data, acc_data;
    wire         d_ready, trap_rst_q, pc_we_q, div_busy;
    logic        tr, pw;
    int          fails = 0, n_checks = 0;
    always #12.5 clk = ~clk;
    cpu_memory_map uut (.clk(clk), .sys_rst(sys_rst), .d_req(d_req), .d_we(d_we),
        .d_byte(d_byte), .d_addr(d_addr), .d_wdata(d_wdata), .d_rdata_q(d_rdata_q),
        .d_ready(d_ready), .trap_rst_q(trap_rst_q), .win_page(win_page), .p_addr(p_addr),
        .p_rdata(p_rdata), .pc_in(pc_in), .pc_we_q(pc_we_q), .ra_sel(ra_sel),
        .rb_sel(rb_sel), .rd_sel(rd_sel), .mul_go(mul_go), .div_go(div_go), .push(push),
        .lnk_go(lnk_go), .ulnk_go(ulnk_go), .div_busy(div_busy), .ra_data(ra_data),
        .acc_data(acc_data));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    // one data access, held until taken, answer sampled after that edge
    task automatic acc(input logic we, bt, input logic [15:0] a, wd);
        int i;
        step;
        d_req = 1'b1;
        d_we = we;
        d_byte = bt;
        d_addr = a;
        d_wdata = wd;
        #1;
        pa = p_addr;
        i = 0;
        while (d_ready !== 1'b1) begin
            i++;
            if (i > 20) begin
                fails++;
                tally_and_finish;
            end
            @(posedge clk);
            #2;
        end
        step;
        d_req = 1'b0;
        r = d_rdata_q;
        tr = trap_rst_q;
        pw = pc_we_q;
    endtask
    task automatic rde(input logic [15:0] a, e);
        acc(1'b0, 1'b0, a, 16'h0000);
        chk({8'h00, r}, {8'h00, e});
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_ram;
        acc(1'b1, 1'b0, 16'h0850, 16'h1234);
        acc(1'b1, 1'b1, 16'h0851, 16'h00ab);
        rde(16'h0850, 16'hab34);
        acc(1'b0, 1'b1, 16'h0851, 16'h0000);
        chk({8'h00, r}, 24'h0000ab);
        acc(1'b1, 1'b0, 16'h27fe, 16'h0f0f);
        rde(16'h27fe, 16'h0f0f);
        acc(1'b1, 1'b0, 16'h0a00, 16'h0200);
        rde(16'h0a00, 16'h0200);
        rde(16'h3000, 16'h0000);
        rde(16'h001e, 16'h0850);
        acc(1'b1, 1'b0, 16'h0000, 16'h5a5a);
        chk({8'h00, acc_data}, 24'h005a5a);
    endtask
    task automatic t_pc_win;
        rde(16'h0020, 16'hbeef);
        acc(1'b1, 1'b0, 16'h0020, 16'h0100);
        chk({23'h0, pw}, 24'h000001);
        rde(16'h8004, 16'hd2e3);
        chk(pa, 24'h030004);
        win_page = 8'h00;
        acc(1'b0, 1'b1, 16'h8001, 16'h0000);
        chk({8'h00, r}, 24'h0000d2);
        chk(pa, 24'h000000);
    endtask
    task automatic t_arith;
        int i;
        acc(1'b1, 1'b0, 16'h0002, 16'h1234);
        acc(1'b1, 1'b0, 16'h0004, 16'h0100);
        ra_sel = 4'h1;
        rb_sel = 4'h2;
        rd_sel = 4'h4;
        mul_go = 1'b1;
        step;
        mul_go = 1'b0;
        chk({8'h00, ra_data}, 24'h001234);
        rde(16'h0008, 16'h3400);
        rde(16'h000a, 16'h0012);
        acc(1'b1, 1'b0, 16'h000c, 16'h0005);
        acc(1'b1, 1'b0, 16'h000e, 16'h0001);
        ra_sel = 4'h6;
        rd_sel = 4'h8;
        div_go = 1'b1;
        step;
        div_go = 1'b0;
        for (i = 0; i < 40 && div_busy !== 1'b0; i++) step;
        chk({23'h0, div_busy}, 24'h000000);
        if (div_busy !== 1'b0) tally_and_finish;
        rde(16'h0010, 16'h0100);
        rde(16'h0012, 16'h0005);
    endtask
    task automatic t_stack_trap;
        ra_sel = 4'h1;
        push = 1'b1;
        step;
        push = 1'b0;
        rde(16'h001e, 16'h0852);
        rde(16'h0850, 16'h1234);
        acc(1'b1, 1'b0, 16'h8850, 16'hffff);
        rde(16'h0850, 16'h1234);
        lnk_go = 1'b1;
        step;
        lnk_go = 1'b0;
        rde(16'h001c, 16'h0854);
        ulnk_go = 1'b1;
        step;
        ulnk_go = 1'b0;
        rde(16'h001c, 16'h0000);
        rde(16'h001e, 16'h0852);
        acc(1'b0, 1'b1, 16'h0853, 16'h0000);
        chk({23'h0, tr}, 24'h000000);
        acc(1'b0, 1'b0, 16'h0853, 16'h0000);
        chk({23'h0, tr}, 24'h000001);
        acc(1'b1, 1'b0, 16'h0853, 16'hdead);
        chk({23'h0, tr}, 24'h000001);
        rde(16'h0852, 16'h0000);
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_ram;
        t_pc_win;
        t_arith;
        t_stack_trap;
        tally_and_finish;
    end
endmodule // cpu_memory_map_test
`default_nettype wire
